// ==== design/i2c_status_clock_reset.v ====
`timescale 1ns/100ps
`include "i2c_status_regs.vh"
// Behaviour
// [R1] status read-only, code in [7:3], low zero
// [R2] idle F8h raises no flag
// [R3] entering defined state loads code, sets flag
// [R4] flag cleared returns code to F8h
// [R5] master transmitter codes 08h..30h
// [R6] arbitration lost codes 38h,68h,78h,B0h
// [R7] master receiver codes 40h..58h
// [R8] slave receiver codes 60h,80h,88h
// [R9] general call codes 70h,90h,98h
// [R10] slave stop or restart gives A0h
// [R11] slave transmitter codes A8h..C8h
// [R12] ten-bit second address D0h/D8h
// [R13] illegal bus condition gives 00h
// [R14] bus error exit: stop plus clear, no STOP
// [R15] start with stop recovers then STARTs
// [R16] status and divider share one address
// [R17] divider: scalar [6:3], exponent [2:0]
// [R18] sample rate is clock over 2^N
// [R19] SCL is clock over 10(M+1)2^N
// [R20] software keeps sample rate tenfold bus rate
// [R21] any write to reset register resets module
// [R22] flag set holds SCL low
// [R23] stop bit self-clears, zero write ignored
// [R24] soft reset: F8h, divider zero, idle
module i2c_status_clock_reset #(
   parameter M_WIDTH = 4,
   parameter N_WIDTH = 3,
   parameter BUF_DEPTH = 2
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire [7:0] io_addr,
   input wire [7:0] io_wdata,
   input wire io_wr,
   input wire io_rd,
   output reg [7:0] io_rdata,
   output reg io_rvalid,
   input wire io_rready,
   input wire event_valid,
   input wire [4:0] event_code,
   output reg event_ready,
   input wire flag_clear,
   input wire start_request_bit,
   input wire stop_request_bit,
   output reg event_pending_flag,
   output reg stop_ack,
   output reg start_issue,
   output reg bus_stop_drive,
   output reg sample_tick,
   output reg scl_tick,
   output reg scl_hold_low,
   output reg master_mode,
   output reg module_reset
);

// ======================================
// state and helpers
localparam S_IDLE = 2'd0;
localparam S_EVENT = 2'd1;
localparam S_BUSERR = 2'd2;

reg [1:0] fsm;
reg [7:0] bus_state_code_reg;
reg [7:0] bus_clock_divider_reg;
reg [7:0] buf_mem [0:BUF_DEPTH-1];
reg buf_wp;
reg buf_rp;
reg [1:0] buf_cnt;
reg [9:0] samp_cnt;
reg [17:0] scl_cnt;
reg [7:0] ev_code;
reg soft_rst;

// decoder for the write side; the read side compares io_addr directly
function addr_hit;
   input [7:0] a;
   input [7:0] target;
   begin
      addr_hit = (a == target);
   end
endfunction

wire [M_WIDTH-1:0] div_m = bus_clock_divider_reg[`DIV_M_HI:`DIV_M_LO]; // R17
wire [N_WIDTH-1:0] div_n = bus_clock_divider_reg[`DIV_N_HI:`DIV_N_LO]; // R17
wire wr_state_div = io_wr && addr_hit(io_addr, `ADDR_STATE_DIV); // R16
wire wr_reset = io_wr && addr_hit(io_addr, `ADDR_SOFT_RESET); // R21
wire buf_out_valid = (buf_cnt != 2'd0);
wire buf_in_ready = (buf_cnt != 2'd2);
wire take_event = buf_out_valid && !event_pending_flag && (fsm == S_IDLE);
wire push = event_valid && buf_in_ready;
// soft reset waits for clk_en, so a frozen block keeps its state
wire soft_clear = soft_rst && clk_en; // R21
// event_ready comes from the next count, so it is registered yet exact
wire [1:0] next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, take_event};

function [9:0] pow2;
   input [2:0] n;
   begin
      pow2 = 10'd1 << n;
   end
endfunction

function [17:0] scl_period;
   input [3:0] m;
   input [2:0] n;
   begin
      scl_period = 18'd10 * ({14'd0, m} + 18'd1) * {8'd0, pow2(n)};
   end
endfunction

// arbitration loss drops master mode, so 38h is not listed
function is_master_code;
   input [7:0] c;
   begin
      case (c)
         `ST_START, `ST_RSTART, `ST_AW_ACK, `ST_AW_NACK, `ST_MTD_ACK, `ST_MTD_NACK:
            is_master_code = 1'b1;
         `ST_AR_ACK, `ST_AR_NACK, `ST_MRD_ACK, `ST_MRD_NACK, `ST_A2W_ACK, `ST_A2W_NACK:
            is_master_code = 1'b1;
         default:
            is_master_code = 1'b0;
      endcase
   end
endfunction

wire [9:0] samp_limit = pow2(div_n) - 10'd1;
wire [17:0] scl_limit = scl_period(div_m, div_n) - 18'd1;

// ======================================
// event buffer
// two entries so a stalled status register loses no event
always @(posedge clk)
begin
   if (!rst_n || soft_clear)
   begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'd0;
      event_ready <= 1'b0;
   end
   else if (clk_en)
   begin
      if (push)
      begin
         buf_mem[buf_wp] <= {event_code, 3'b000};
         buf_wp <= ~buf_wp;
      end
      if (take_event)
         buf_rp <= ~buf_rp;
      buf_cnt <= next_buf_cnt;
      event_ready <= (next_buf_cnt != 2'd2);
   end
end

always @*
begin
   ev_code = buf_mem[buf_rp];
end

// ======================================
// status machine
always @(posedge clk)
begin
   if (!rst_n || soft_clear)
   begin
      fsm <= S_IDLE;
      bus_state_code_reg <= `ST_IDLE; // R24
      event_pending_flag <= 1'b0;
      stop_ack <= 1'b0;
      start_issue <= 1'b0;
      bus_stop_drive <= 1'b0;
      master_mode <= 1'b0;
      scl_hold_low <= 1'b0;
   end
   else if (clk_en)
   begin
      stop_ack <= 1'b0;
      start_issue <= 1'b0;
      bus_stop_drive <= 1'b0;
      case (fsm)
         S_IDLE:
         begin
            // F8h leaves the buffer without touching the flag
            if (take_event && ev_code != `ST_IDLE) // R2
            begin
               bus_state_code_reg <= ev_code; // R3 R5 R6 R7 R8 R9 R10 R11 R12
               event_pending_flag <= 1'b1; // R3
               scl_hold_low <= 1'b1; // R22
               master_mode <= is_master_code(ev_code); // R19
               if (ev_code == `ST_BUS_ERR) // R13
               begin
                  fsm <= S_BUSERR;
                  master_mode <= 1'b0;
               end
               else
                  fsm <= S_EVENT;
            end
         end
         S_EVENT:
         begin
            if (flag_clear)
            begin
               event_pending_flag <= 1'b0;
               scl_hold_low <= 1'b0; // R22
               bus_state_code_reg <= `ST_IDLE; // R4
               fsm <= S_IDLE;
               if (stop_request_bit)
               begin
                  stop_ack <= 1'b1; // R23
                  bus_stop_drive <= master_mode;
                  master_mode <= 1'b0;
               end
            end
         end
         S_BUSERR:
         begin
            // leaving needs stop and clear together; no STOP driven
            if (flag_clear && stop_request_bit) // R14
            begin
               event_pending_flag <= 1'b0;
               scl_hold_low <= 1'b0;
               bus_state_code_reg <= `ST_IDLE; // R4
               stop_ack <= 1'b1; // R23
               start_issue <= start_request_bit; // R15
               fsm <= S_IDLE;
            end
         end
         default:
            fsm <= S_IDLE;
      endcase
   end
end

// ======================================
// register reads
always @(posedge clk)
begin
   if (!rst_n || soft_clear)
   begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
   end
   else if (clk_en)
   begin
      // an unaccepted answer stands; a read issued meanwhile is dropped
      if (io_rvalid && !io_rready)
         io_rvalid <= 1'b1;
      else if (io_rd)
      begin
         io_rvalid <= 1'b1;
         if (io_addr == `ADDR_STATE_DIV)
            io_rdata <= {bus_state_code_reg[7:3], 3'b000}; // R1 R16
         else
            io_rdata <= 8'h00;
      end
      else
         io_rvalid <= 1'b0;
   end
end

// ======================================
// divider register and soft reset
// soft reset lasts one cycle; module_reset mirrors it outward
always @(posedge clk)
begin
   if (!rst_n)
   begin
      soft_rst <= 1'b0;
      module_reset <= 1'b0;
   end
   else if (clk_en)
   begin
      soft_rst <= wr_reset; // R21
      module_reset <= wr_reset;
   end
end

always @(posedge clk)
begin
   if (!rst_n || soft_clear)
      bus_clock_divider_reg <= `DIV_RESET; // R24
   else if (clk_en && wr_state_div)
      bus_clock_divider_reg <= {1'b0, io_wdata[6:0]}; // R16 R17
end

// ======================================
// sample divider
// software must keep sample rate tenfold the fastest master
always @(posedge clk)
begin
   if (!rst_n || soft_clear)
   begin
      samp_cnt <= 10'd0;
      sample_tick <= 1'b0;
   end
   else if (clk_en)
   begin
      if (samp_cnt >= samp_limit) // R18 R20
      begin
         samp_cnt <= 10'd0;
         sample_tick <= 1'b1;
      end
      else
      begin
         samp_cnt <= samp_cnt + 10'd1;
         sample_tick <= 1'b0;
      end
   end
end

// ======================================
// SCL divider
// restarts while stretched, so a released line gets a full period
always @(posedge clk)
begin
   if (!rst_n || soft_clear)
   begin
      scl_cnt <= 18'd0;
      scl_tick <= 1'b0;
   end
   else if (clk_en)
   begin
      if (!master_mode || scl_hold_low) // R22
      begin
         scl_cnt <= 18'd0;
         scl_tick <= 1'b0;
      end
      else if (scl_cnt >= scl_limit) // R19
      begin
         scl_cnt <= 18'd0;
         scl_tick <= 1'b1;
      end
      else
      begin
         scl_cnt <= scl_cnt + 18'd1;
         scl_tick <= 1'b0;
      end
   end
end

endmodule // i2c_status_clock_reset

// ==== common/i2c_status_regs.vh ====
`ifndef I2C_STATUS_REGS_VH
`define I2C_STATUS_REGS_VH
// ======================================
// register addresses
`define ADDR_STATE_DIV 8'hCC
`define ADDR_SOFT_RESET 8'hCD
// ======================================
// fields
`define DIV_M_HI 6
`define DIV_M_LO 3
`define DIV_N_HI 2
`define DIV_N_LO 0
`define DIV_RESET 8'h00
`define SCL_FIXED_DIV 10
// ======================================
// status codes
`define ST_BUS_ERR 8'h00
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_AW_ACK 8'h18
`define ST_AW_NACK 8'h20
`define ST_MTD_ACK 8'h28
`define ST_MTD_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_AR_ACK 8'h40
`define ST_AR_NACK 8'h48
`define ST_MRD_ACK 8'h50
`define ST_MRD_NACK 8'h58
`define ST_SW_ACK 8'h60
`define ST_ARB_SW 8'h68
`define ST_GC_ACK 8'h70
`define ST_ARB_GC 8'h78
`define ST_SRD_ACK 8'h80
`define ST_SRD_NACK 8'h88
`define ST_GCD_ACK 8'h90
`define ST_GCD_NACK 8'h98
`define ST_SLV_STOP 8'hA0
`define ST_SR_ACK 8'hA8
`define ST_ARB_SR 8'hB0
`define ST_STD_ACK 8'hB8
`define ST_STD_NACK 8'hC0
`define ST_STD_LAST 8'hC8
`define ST_A2W_ACK 8'hD0
`define ST_A2W_NACK 8'hD8
`define ST_IDLE 8'hF8
`endif

// ==== tb/i2c_status_properties.sv ====
`timescale 1ns/100ps
// ==========
// port checker
module i2c_status_props (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire [7:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_rdata,
   input wire io_rvalid,
   input wire flag_clear,
   input wire event_pending_flag,
   input wire scl_hold_low,
   input wire scl_tick,
   input wire module_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   read_answer_a:
      assert property (io_rd && clk_en && !io_rvalid |=> io_rvalid) else $error("no answer");
   low_bits_a:
      assert property (io_rvalid |-> io_rdata[2:0] == 3'h0) else $error("low bits");
   flag_clear_a:
      assert property (event_pending_flag && flag_clear && clk_en |=> !event_pending_flag) else $error("kept");
   // soft reset also drops the flag, so its cycles are left out
   flag_stand_a:
      assert property (event_pending_flag && !flag_clear && !module_reset && !io_wr |=> event_pending_flag)
      else $error("lost");
   hold_low_a:
      assert property (event_pending_flag |-> scl_hold_low) else $error("not held");
   hold_release_a:
      assert property ($fell(event_pending_flag) |-> !scl_hold_low) else $error("not released");
   scl_gap_a:
      assert property (scl_tick |=> !scl_tick [*8]) else $error("scl fast");
   soft_reset_a:
      assert property (io_wr && clk_en && io_addr == 8'hCD |-> ##[1:2] module_reset) else $error("no reset");
   cover property (event_pending_flag && flag_clear);
   cover property (module_reset);
   cover property (scl_tick);
endmodule // i2c_status_props
bind i2c_status_clock_reset i2c_status_props i2c_status_props_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
   .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
   .flag_clear(flag_clear), .event_pending_flag(event_pending_flag), .scl_hold_low(scl_hold_low),
   .scl_tick(scl_tick), .module_reset(module_reset));

// ==== tb/bus_event_source.sv ====
`timescale 1ns/100ps
// ==========
// bus engine stand-in
module bus_event_source (
   input wire clk,
   input wire rst_n,
   input wire go,
   input wire [4:0] code,
   input wire event_ready,
   output reg event_valid,
   output reg [4:0] event_code
);
   always @(posedge clk)
   begin
      if (!rst_n)
         event_valid <= 1'b0;
      else if (go)
      begin
         event_valid <= 1'b1;
         event_code <= code;
      end
      else if (event_ready || !event_valid)
      begin
         event_valid <= 1'b0;
         // toggled so a stale code is never mistaken for a held one
         event_code <= ~event_code;
      end
   end
endmodule // bus_event_source

// ==== tb/tb_i2c_status_clock_reset.sv ====
`timescale 1ns/100ps
// ==========
// bench
module tb_i2c_status_clock_reset;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] io_addr = 8'h00;
   reg [7:0] io_wdata = 8'h00;
   reg io_wr = 1'b0;
   reg io_rd = 1'b0;
   reg go = 1'b0;
   reg [4:0] code = 5'h00;
   reg flag_clear = 1'b0;
   reg start_request_bit = 1'b0;
   reg stop_request_bit = 1'b0;
   reg clk_en = 1'b1;
   reg io_rready = 1'b1;
   wire [7:0] io_rdata;
   wire [4:0] event_code;
   wire io_rvalid, event_valid, event_ready, event_pending_flag, stop_ack, start_issue, bus_stop_drive;
   wire sample_tick, scl_tick, scl_hold_low, master_mode, module_reset;
   integer err_total = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer n;
   reg [4:0] k;
   reg [7:0] rd;
   reg [2:0] seen;
   initial
   begin
      forever #2 clk = ~clk;
   end
   i2c_status_clock_reset i2c_status_clock_reset_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .io_rready(io_rready), .event_valid(event_valid), .event_code(event_code), .event_ready(event_ready),
      .flag_clear(flag_clear), .start_request_bit(start_request_bit), .stop_request_bit(stop_request_bit),
      .event_pending_flag(event_pending_flag), .stop_ack(stop_ack), .start_issue(start_issue),
      .bus_stop_drive(bus_stop_drive), .sample_tick(sample_tick), .scl_tick(scl_tick),
      .scl_hold_low(scl_hold_low), .master_mode(master_mode), .module_reset(module_reset));
   bus_event_source bus_event_source_i (.clk(clk), .rst_n(rst_n), .go(go), .code(code),
      .event_ready(event_ready), .event_valid(event_valid), .event_code(event_code));
   task chk(input [7:0] got, input [7:0] exp, input string m);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("BAD %0t %s got %h want %h", $time, m, got, exp);
      end
   end
   endtask
   task rd_reg(input [7:0] a);
   begin
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      chk({7'h00, io_rvalid}, 8'h01, "rvalid");
      rd = io_rdata;
   end
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
   begin
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   end
   endtask
   task send(input [4:0] c);
   begin
      code = c;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (n = 0; n < 20 && event_valid !== 1'b0; n = n + 1)
         @(negedge clk);
      for (n = 0; n < 20 && event_pending_flag !== 1'b1; n = n + 1)
         @(negedge clk);
   end
   endtask
   task clr;
   begin
      flag_clear = 1'b1;
      @(negedge clk);
      flag_clear = 1'b0;
      @(negedge clk);
   end
   endtask
   task gap(input sel, input [7:0] want);
   begin
      for (n = 0; n < 200 && (sel ? scl_tick : sample_tick) !== 1'b1; n = n + 1)
         @(negedge clk);
      @(negedge clk);
      for (n = 1; n < 200 && (sel ? scl_tick : sample_tick) !== 1'b1; n = n + 1)
         @(negedge clk);
      chk(n[7:0], want, "tick gap");
   end
   endtask
   task t_codes;
   begin
      for (k = 5'h01; k < 5'h1C; k = k + 5'h01)
      begin
         send(k);
         chk({7'h00, scl_hold_low}, 8'h01, "hold");
         rd_reg(8'hCC);
         chk(rd, {k, 3'h0}, "code");
         clr;
         rd_reg(8'hCC);
         chk(rd, 8'hF8, "idle");
      end
      send(5'h1F);
      chk({7'h00, event_pending_flag}, 8'h00, "idle flag");
      $display("codes test end");
   end
   endtask
   task t_err(input st);
   begin
      send(5'h00);
      rd_reg(8'hCC);
      chk(rd, 8'h00, "error code");
      stop_request_bit = 1'b1;
      start_request_bit = st;
      flag_clear = 1'b1;
      seen = 3'h0;
      repeat (6)
      begin
         @(negedge clk);
         flag_clear = 1'b0;
         seen = seen | {stop_ack, start_issue, bus_stop_drive};
      end
      stop_request_bit = 1'b0;
      start_request_bit = 1'b0;
      chk({5'h00, seen}, {5'h00, 1'h1, st, 1'h0}, "recovery");
      rd_reg(8'hCC);
      chk(rd, 8'hF8, "after error");
      $display("error test end");
   end
   endtask
   task t_stop(input [4:0] c, input drive);
   begin
      send(c);
      stop_request_bit = 1'b1;
      flag_clear = 1'b1;
      @(negedge clk);
      flag_clear = 1'b0;
      chk({6'h00, stop_ack, bus_stop_drive}, {6'h00, 1'b1, drive}, "stop");
      @(negedge clk);
      stop_request_bit = 1'b0;
      chk({6'h00, stop_ack, master_mode}, 8'h00, "stop done");
      rd_reg(8'hCC);
      chk(rd, 8'hF8, "after stop");
      $display("stop test end");
   end
   endtask
   task t_hold;
   begin
      io_rready = 1'b0;
      rd_reg(8'hCC);
      @(negedge clk);
      chk({7'h00, io_rvalid}, 8'h01, "answer held");
      io_rready = 1'b1;
      @(negedge clk);
      chk({7'h00, io_rvalid}, 8'h00, "answer taken");
      send(5'h01);
      clk_en = 1'b0;
      flag_clear = 1'b1;
      repeat (3) @(negedge clk);
      chk({6'h00, event_pending_flag, scl_hold_low}, 8'h03, "frozen");
      flag_clear = 1'b0;
      clk_en = 1'b1;
      clr;
      $display("hold test end");
   end
   endtask
   task t_fill;
   begin
      send(5'h01);
      send(5'h02);
      send(5'h03);
      chk({7'h00, event_ready}, 8'h00, "buffer full");
      clr;
      send(5'h1F);
      rd_reg(8'hCC);
      chk(rd, 8'h10, "second");
      clr;
      send(5'h1F);
      rd_reg(8'hCC);
      chk(rd, 8'h18, "third");
      clr;
      $display("buffer test end");
   end
   endtask
   task t_div_reset;
   begin
      wr_reg(8'hCC, 8'h89);
      gap(1'b0, 8'h02);
      send(5'h01);
      clr;
      gap(1'b1, 8'h28);
      rd_reg(8'hCC);
      chk(rd, 8'hF8, "shared address");
      send(5'h05);
      wr_reg(8'hCD, 8'h5A);
      chk({7'h00, module_reset}, 8'h01, "reset pulse");
      repeat (3) @(negedge clk);
      chk({6'h00, master_mode, event_pending_flag}, 8'h00, "soft reset");
      rd_reg(8'hCC);
      chk(rd, 8'hF8, "reset status");
      gap(1'b0, 8'h01);
      $display("divider test end");
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         err_total = err_total + 1;
         $display("BAD %0t timeout", $time);
         report_and_stop;
      end
   end
   initial
   begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      rd_reg(8'hCC);
      chk(rd, 8'hF8, "reset value");
      t_codes;
      t_err(1'b0);
      t_err(1'b1);
      t_stop(5'h05, 1'b1);
      t_stop(5'h0C, 1'b0);
      t_hold;
      t_fill;
      t_div_reset;
      report_and_stop;
   end
endmodule // tb_i2c_status_clock_reset
